// >>> rtl/pwc_pkg.sv
// constants, frame layout and state type for the parameter write handler
// assumes byte framing and inter-frame silence detection are done upstream
package pwc_pkg;
  // ---------------------------------------------------------------
  // command codes and exception answers
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_WR1    = 8'h06;
  localparam logic [7:0]  CMD_WR1_NR = 8'h41;
  localparam logic [7:0]  CMD_WRN    = 8'h10;
  localparam logic [7:0]  CMD_WRN_NR = 8'h43;
  localparam logic [7:0]  EXC_FLAG   = 8'h80;
  localparam logic [7:0]  EXC_FUNC   = 8'h01;
  localparam logic [7:0]  EXC_ADDR   = 8'h02;
  localparam logic [7:0]  EXC_DATA   = 8'h03;
  // ---------------------------------------------------------------
  // frame check
  // ---------------------------------------------------------------
  localparam logic [15:0] CRC_INIT   = 16'hffff;
  localparam logic [15:0] CRC_POLY   = 16'ha001;
  // ---------------------------------------------------------------
  // frame layout, byte offsets
  // ---------------------------------------------------------------
  localparam int          BUF_DEPTH  = 64;
  localparam int          OFS_SLAVE  = 0;
  localparam int          OFS_CMD    = 1;
  localparam int          OFS_ADDR   = 2;
  localparam int          OFS_CNT    = 4;
  localparam int          OFS_BCNT   = 6;
  localparam logic [5:0]  OFS_VAL1   = 6'h04;
  localparam logic [5:0]  OFS_DATA   = 6'h07;
  localparam logic [6:0]  LEN_SINGLE = 7'h08;
  localparam logic [6:0]  LEN_OVH    = 7'h09;
  localparam logic [6:0]  LEN_MIN    = 7'h04;
  localparam int          MODE_BIT   = 15;
  localparam logic [15:0] HALF_ONES  = 16'hffff;
  localparam logic [15:0] HALF_ZERO  = 16'h0000;
  localparam logic [3:0]  ECHO_LEN   = 4'h6;
  localparam logic [3:0]  EXC_LEN    = 4'h3;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CRC_RST    = 16'hffff;
  localparam logic [6:0]  CNT_RST    = 7'h00;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PARSE = 3'h1,
    ST_CHK   = 3'h2,
    ST_NEXT  = 3'h3,
    ST_RESP  = 3'h4
  } pwc_state_t;
endpackage : pwc_pkg

// >>> rtl/pwc_param_write.sv
// parameter write command handler: frame receive, check, commit, answer
// assumes RX bytes arrive one per RX_VALID and RX_END pulses after the
// last byte of a frame; PA_* attributes follow PW_ADDR within one cycle
//
// Functional notes
// R1: codes 06/41 write one 16-bit parameter only
// R2: single write with address top bit: address exception
// R3: host uses 16-bit mode only within 16-bit range
// R4: long signed target: extend upper half from bit 15
// R5: commit only if in range and changeable
// R6: unsigned targets never extended, upper half ignored
// R7: codes 10/43 write consecutive parameters, both modes
// R8: 32-bit mode: each value is four data bytes
// R9: address top bit selects 32-bit mode, then stripped
// R10: 32-bit mode register count is twice parameters
// R11: multi frame: addr, code, start, count, bytes, data, crc
// R12: success answer echoes six bytes plus fresh check
// R13: failed write answers with an exception frame
// R14: 32-bit mode writes any length if valid
// R15: function class: one bad value blocks all
// R16: control class: commit up to first bad one
// R17: codes 06/10 retention follows retention select
// R18: signed class and unsigned class handled apart
// R19: check is reflected crc16, init ffff, poly a001
// R20: bad check frames dropped without any write
`timescale 1ns/100ps
`default_nettype none
module pwc_param_write (
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  SLAVE_ADDR,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_END,
  output var  logic [7:0]  TX_DATA,
  output var  logic        TX_VALID,
  output var  logic        TX_LAST,
  input  wire logic        TX_READY,
  output var  logic [15:0] PW_ADDR,
  output var  logic [31:0] PW_DATA,
  output var  logic        PW_WE,
  output var  logic        PW_RETAIN,
  input  wire logic        PA_SIGNED,
  input  wire logic        PA_LONG,
  input  wire logic        PA_CTRL,
  input  wire logic        PA_WRITABLE,
  input  wire logic [31:0] PA_MIN,
  input  wire logic [31:0] PA_MAX,
  input  wire logic        POWER_LOSS_RETENTION_SELECT,
  output var  logic        BUSY
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ pwc_pkg::CRC_POLY) : (r >> 1); // see R19
    return r;
  endfunction : crc_step

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]          bufm [0:pwc_pkg::BUF_DEPTH-1];
  pwc_pkg::pwc_state_t st_r, st_nxt;
  logic [6:0]          cnt_r, cnt_nxt;
  logic                ovf_r, ovf_nxt;
  logic [15:0]         crc_r, crc_nxt;
  logic                buf_we;
  logic                mode32_r, mode32_nxt;
  logic                val_r, val_nxt;
  logic                first_r, first_nxt;
  logic                ctrl_r, ctrl_nxt;
  logic [5:0]          idx_r, idx_nxt;
  logic [6:0]          n_r, n_nxt;
  logic [6:0]          np_r, np_nxt;
  logic [14:0]         start_r, start_nxt;
  logic                exc_r, exc_nxt;
  logic [7:0]          code_r, code_nxt;
  logic [3:0]          t_r, t_nxt;
  logic [15:0]         txc_r, txc_nxt;
  logic [7:0]          tx_data_nxt;
  logic                tx_valid_nxt, tx_last_nxt;
  logic [15:0]         pw_addr_nxt;
  logic [31:0]         pw_data_nxt;
  logic                pw_we_nxt, pw_ret_nxt, busy_nxt;

  // decoded frame fields
  logic [7:0]  cmd;
  logic [15:0] f_addr, f_cnt;
  logic [7:0]  f_bcnt;
  logic        is_single, is_multi;
  assign cmd       = bufm[pwc_pkg::OFS_CMD];
  assign f_addr    = {bufm[pwc_pkg::OFS_ADDR], bufm[pwc_pkg::OFS_ADDR+1]};
  assign f_cnt     = {bufm[pwc_pkg::OFS_CNT], bufm[pwc_pkg::OFS_CNT+1]};
  assign f_bcnt    = bufm[pwc_pkg::OFS_BCNT];
  assign is_single = (cmd == pwc_pkg::CMD_WR1) || (cmd == pwc_pkg::CMD_WR1_NR);
  assign is_multi  = (cmd == pwc_pkg::CMD_WRN) || (cmd == pwc_pkg::CMD_WRN_NR);

  // ---------------------------------------------------------------
  // value shaping and range check
  // ---------------------------------------------------------------
  logic [15:0] w16;
  logic [31:0] w32, wval;
  logic        in_rng, ok, cls;
  always_comb
  begin
    w16 = {bufm[idx_r], bufm[idx_r + 6'h01]};
    w32 = {w16, bufm[idx_r + 6'h02], bufm[idx_r + 6'h03]}; // see R8
    if (mode32_r)
      wval = w32; // see R14
    else if (PA_SIGNED && w16[15])
      wval = {pwc_pkg::HALF_ONES, w16}; // see R4
    else
      wval = {pwc_pkg::HALF_ZERO, w16}; // see R6
    if (PA_SIGNED)
      in_rng = ($signed(wval) >= $signed(PA_MIN)) && ($signed(wval) <= $signed(PA_MAX)); // see R18
    else
      in_rng = (wval >= PA_MIN) && (wval <= PA_MAX);
    ok  = in_rng && PA_WRITABLE; // see R5
    cls = first_r ? PA_CTRL : ctrl_r;
  end

  // ---------------------------------------------------------------
  // sequencer next values
  // ---------------------------------------------------------------
  logic [6:0] params;
  logic       good, len_ok;
  logic [3:0] blen;
  always_comb
  begin
    st_nxt = st_r; cnt_nxt = cnt_r; ovf_nxt = ovf_r; crc_nxt = crc_r; buf_we = 1'b0;
    mode32_nxt = mode32_r; val_nxt = val_r; first_nxt = first_r; ctrl_nxt = ctrl_r;
    idx_nxt = idx_r; n_nxt = n_r; np_nxt = np_r; start_nxt = start_r;
    exc_nxt = exc_r; code_nxt = code_r; t_nxt = t_r; txc_nxt = txc_r;
    tx_data_nxt = TX_DATA; tx_valid_nxt = TX_VALID; tx_last_nxt = TX_LAST;
    pw_addr_nxt = PW_ADDR; pw_data_nxt = PW_DATA; pw_we_nxt = 1'b0; pw_ret_nxt = PW_RETAIN;
    // the mode bit of the frame itself, not the previous frame's mode
    params = f_cnt[6:0] >> f_addr[pwc_pkg::MODE_BIT];
    good   = (crc_r == 16'h0000) && !ovf_r && (cnt_r >= pwc_pkg::LEN_MIN)
             && (bufm[pwc_pkg::OFS_SLAVE] == SLAVE_ADDR);
    len_ok = 1'b0;
    blen   = exc_r ? pwc_pkg::EXC_LEN : pwc_pkg::ECHO_LEN;
    case (st_r)
      pwc_pkg::ST_IDLE:
      begin
        if (RX_VALID)
        begin
          crc_nxt = crc_step(crc_r, RX_DATA); // see R19
          if (cnt_r < 7'(pwc_pkg::BUF_DEPTH))
          begin
            buf_we  = 1'b1;
            cnt_nxt = cnt_r + 7'h01;
          end
          else
            ovf_nxt = 1'b1;
        end
        else if (RX_END)
          st_nxt = pwc_pkg::ST_PARSE;
      end
      pwc_pkg::ST_PARSE:
      begin
        cnt_nxt = pwc_pkg::CNT_RST;
        crc_nxt = pwc_pkg::CRC_RST;
        ovf_nxt = 1'b0;
        first_nxt = 1'b1;
        exc_nxt = 1'b0;
        st_nxt = pwc_pkg::ST_RESP;
        if (!good)
          st_nxt = pwc_pkg::ST_IDLE; // see R20
        else if (is_single)
        begin
          mode32_nxt = 1'b0; // see R1
          if (cnt_r != pwc_pkg::LEN_SINGLE)
          begin
            exc_nxt  = 1'b1;
            code_nxt = pwc_pkg::EXC_DATA;
          end
          else if (f_addr[pwc_pkg::MODE_BIT])
          begin
            exc_nxt  = 1'b1; // see R2
            code_nxt = pwc_pkg::EXC_ADDR;
          end
          else
          begin
            val_nxt = 1'b0;
            idx_nxt = pwc_pkg::OFS_VAL1;
            n_nxt = 7'h01;
            np_nxt = 7'h01;
            start_nxt = f_addr[14:0];
            pw_addr_nxt = f_addr;
            st_nxt = pwc_pkg::ST_CHK;
          end
        end
        else if (is_multi)
        begin
          mode32_nxt = f_addr[pwc_pkg::MODE_BIT]; // see R9
          len_ok = (cnt_r == pwc_pkg::LEN_OVH + f_bcnt[6:0]) && (f_cnt != 16'h0000)
                   && (f_bcnt < 8'(pwc_pkg::BUF_DEPTH))
                   && ({f_cnt[14:0], 1'b0} == {8'h00, f_bcnt}) // see R11
                   && !(mode32_nxt && f_cnt[0]); // see R10
          if (!len_ok)
          begin
            exc_nxt  = 1'b1;
            code_nxt = pwc_pkg::EXC_DATA;
          end
          else
          begin
            val_nxt = 1'b1; // see R7
            idx_nxt = pwc_pkg::OFS_DATA;
            n_nxt = params;
            np_nxt = params;
            start_nxt = f_addr[14:0];
            pw_addr_nxt = {1'b0, f_addr[14:0]}; // see R9
            st_nxt = pwc_pkg::ST_CHK;
          end
        end
        else
        begin
          exc_nxt  = 1'b1;
          code_nxt = pwc_pkg::EXC_FUNC;
        end
        t_nxt   = 4'h0;
        txc_nxt = pwc_pkg::CRC_INIT;
      end
      pwc_pkg::ST_CHK:
      begin
        first_nxt = 1'b0;
        ctrl_nxt  = cls;
        val_nxt   = val_r && !cls; // see R16
        if (!ok)
        begin
          // earlier control-class commits stay; nothing here is written
          exc_nxt  = 1'b1; // see R13
          code_nxt = pwc_pkg::EXC_DATA;
          st_nxt   = pwc_pkg::ST_RESP;
        end
        else
        begin
          if (!(val_r && !cls))
          begin
            pw_we_nxt   = 1'b1; // see R5
            pw_data_nxt = wval;
            pw_ret_nxt  = ((cmd == pwc_pkg::CMD_WR1) || (cmd == pwc_pkg::CMD_WRN))
                          && POWER_LOSS_RETENTION_SELECT; // see R17
          end
          st_nxt = pwc_pkg::ST_NEXT;
        end
      end
      pwc_pkg::ST_NEXT:
      begin
        st_nxt = pwc_pkg::ST_CHK;
        if (n_r == 7'h01)
        begin
          if (val_r)
          begin
            // all values passed the dry run, now write them for real
            val_nxt = 1'b0; // see R15
            idx_nxt = pwc_pkg::OFS_DATA;
            n_nxt = np_r;
            pw_addr_nxt = {1'b0, start_r};
          end
          else
            st_nxt = pwc_pkg::ST_RESP;
        end
        else
        begin
          n_nxt = n_r - 7'h01;
          idx_nxt = idx_r + (mode32_r ? 6'h04 : 6'h02);
          pw_addr_nxt = PW_ADDR + 16'h0001;
        end
      end
      pwc_pkg::ST_RESP:
      begin
        if (!TX_VALID || TX_READY)
        begin
          if (t_r < blen + 4'h2)
          begin
            if (t_r < blen)
            begin
              if (exc_r && t_r == 4'h1)
                tx_data_nxt = cmd | pwc_pkg::EXC_FLAG;
              else if (exc_r && t_r == 4'h2)
                tx_data_nxt = code_r;
              else
                tx_data_nxt = bufm[t_r]; // see R12
              txc_nxt = crc_step(txc_r, tx_data_nxt);
            end
            else
              tx_data_nxt = (t_r == blen) ? txc_r[7:0] : txc_r[15:8]; // see R19
            tx_valid_nxt = 1'b1;
            tx_last_nxt  = (t_r == blen + 4'h1);
            t_nxt = t_r + 4'h1;
          end
          else
          begin
            tx_valid_nxt = 1'b0;
            tx_last_nxt  = 1'b0;
            st_nxt = pwc_pkg::ST_IDLE;
          end
        end
      end
      default:
        st_nxt = pwc_pkg::ST_IDLE;
    endcase
    busy_nxt = (st_nxt != pwc_pkg::ST_IDLE);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (buf_we)
      bufm[cnt_r[5:0]] <= RX_DATA;
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= pwc_pkg::ST_IDLE; cnt_r <= pwc_pkg::CNT_RST; ovf_r <= 1'b0;
      crc_r <= pwc_pkg::CRC_RST; mode32_r <= 1'b0; val_r <= 1'b0; first_r <= 1'b0;
      ctrl_r <= 1'b0; idx_r <= 6'h00; n_r <= 7'h00; np_r <= 7'h00; start_r <= 15'h0000;
      exc_r <= 1'b0; code_r <= 8'h00; t_r <= 4'h0; txc_r <= pwc_pkg::CRC_RST;
      TX_DATA <= 8'h00; TX_VALID <= 1'b0; TX_LAST <= 1'b0;
      PW_ADDR <= 16'h0000; PW_DATA <= 32'h0000_0000; PW_WE <= 1'b0;
      PW_RETAIN <= 1'b0; BUSY <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt; cnt_r <= cnt_nxt; ovf_r <= ovf_nxt; crc_r <= crc_nxt;
      mode32_r <= mode32_nxt; val_r <= val_nxt; first_r <= first_nxt; ctrl_r <= ctrl_nxt;
      idx_r <= idx_nxt; n_r <= n_nxt; np_r <= np_nxt; start_r <= start_nxt;
      exc_r <= exc_nxt; code_r <= code_nxt; t_r <= t_nxt; txc_r <= txc_nxt;
      TX_DATA <= tx_data_nxt; TX_VALID <= tx_valid_nxt; TX_LAST <= tx_last_nxt;
      PW_ADDR <= pw_addr_nxt; PW_DATA <= pw_data_nxt; PW_WE <= pw_we_nxt;
      PW_RETAIN <= pw_ret_nxt; BUSY <= busy_nxt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_single_16;
    @(posedge MCLK) disable iff (!rst_n) PW_WE && is_single |-> !mode32_r;
  endproperty
  a_single_16: assert property (p_single_16) else $error("single write in 32-bit mode"); // see R1

  property p_addr_exc;
    @(posedge MCLK) disable iff (!rst_n)
      st_r == pwc_pkg::ST_PARSE && good && is_single && cnt_r == pwc_pkg::LEN_SINGLE
      && f_addr[pwc_pkg::MODE_BIT] |=> exc_r && code_r == pwc_pkg::EXC_ADDR && !PW_WE [*3];
  endproperty
  a_addr_exc: assert property (p_addr_exc) else $error("top address bit not refused"); // see R2

  property p_sign_ext;
    @(posedge MCLK) disable iff (!rst_n)
      PW_WE && !mode32_r && PA_SIGNED |-> PW_DATA[31:16] == {16{PW_DATA[15]}};
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("signed value not extended"); // see R4

  property p_writable;
    @(posedge MCLK) disable iff (!rst_n) PW_WE |-> $past(ok) && $past(PA_WRITABLE);
  endproperty
  a_writable: assert property (p_writable) else $error("write to locked parameter"); // see R5

  property p_unsigned;
    @(posedge MCLK) disable iff (!rst_n)
      PW_WE && !mode32_r && !PA_SIGNED |-> PW_DATA[31:16] == pwc_pkg::HALF_ZERO;
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("unsigned value extended"); // see R6

  property p_strip;
    @(posedge MCLK) disable iff (!rst_n) PW_WE |-> !PW_ADDR[pwc_pkg::MODE_BIT];
  endproperty
  a_strip: assert property (p_strip) else $error("mode bit left in address"); // see R9

  property p_crc_drop;
    @(posedge MCLK) disable iff (!rst_n)
      st_r == pwc_pkg::ST_PARSE && crc_r != 16'h0000 |=> st_r == pwc_pkg::ST_IDLE && !PW_WE;
  endproperty
  a_crc_drop: assert property (p_crc_drop) else $error("bad check frame acted on"); // see R20

  property p_retain;
    @(posedge MCLK) disable iff (!rst_n)
      PW_WE && (cmd == pwc_pkg::CMD_WR1_NR || cmd == pwc_pkg::CMD_WRN_NR) |-> !PW_RETAIN;
  endproperty
  a_retain: assert property (p_retain) else $error("retention on volatile code"); // see R17

  property p_atomic;
    @(posedge MCLK) disable iff (!rst_n)
      st_r == pwc_pkg::ST_CHK && val_r && !cls && !ok |=> !PW_WE ##1 exc_r;
  endproperty
  a_atomic: assert property (p_atomic) else $error("partial function write"); // see R15
endmodule : pwc_param_write
`default_nettype wire

// >>> tb/pwc_host_model.sv
// host side of the serial link: sends request frames, collects answer bytes
// assumes answer bytes leave on MCLK edges where TX_VALID and TX_READY are high
`timescale 1ns/100ps
`default_nettype none
module pwc_host_model (
  input  wire logic       MCLK,
  output var  logic       RX_VALID,
  output var  logic [7:0] RX_DATA,
  output var  logic       RX_END,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_VALID,
  input  wire logic       TX_LAST,
  output var  logic       TX_READY
);
  // each entry holds the last-byte flag above the answer byte
  logic [8:0] ans_q[$];
  logic       stall;

  initial
  begin
    RX_VALID = 1'b0;
    RX_DATA  = 8'h00;
    RX_END   = 1'b0;
    TX_READY = 1'b0;
    stall    = 1'b0;
  end

  // ---------------------------------------------------------------
  // frame check, reflected, low byte sent first
  // ---------------------------------------------------------------
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = pwc_pkg::CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ pwc_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // ---------------------------------------------------------------
  // request sender
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] q[$], input logic good);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, ~good};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      @(posedge MCLK);
      #1;
      RX_VALID = 1'b1;
      RX_DATA  = q[i];
    end
    @(posedge MCLK);
    #1;
    RX_VALID = 1'b0;
    // released line shows the inverse, not a stale byte
    RX_DATA  = ~RX_DATA;
    RX_END   = 1'b1;
    @(posedge MCLK);
    #1;
    RX_END   = 1'b0;
  endtask : send

  // ---------------------------------------------------------------
  // answer sink, optionally stalling every other cycle
  // ---------------------------------------------------------------
  always @(posedge MCLK)
  begin
    if (TX_VALID && TX_READY)
      ans_q.push_back({TX_LAST, TX_DATA});
    #1;
    TX_READY = stall ? ~TX_READY : 1'b1;
  end
endmodule : pwc_host_model
`default_nettype wire

// >>> tb/test_param_write_command_handler.sv
// self-checking bench for the parameter write handler
// assumes the host model drives the link and this bench serves the attributes
`timescale 1ns/100ps
`default_nettype none
module test_param_write_command_handler;
  logic        mclk;
  logic        rstn;
  logic        retain_sel;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_end;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_last;
  logic        tx_ready;
  logic [15:0] pw_addr;
  logic [31:0] pw_data;
  logic        pw_we;
  logic        pw_retain;
  logic        busy;
  logic        pa_signed;
  logic        pa_long;
  logic        pa_ctrl;
  logic        pa_writable;
  logic [31:0] pa_min;
  logic [31:0] pa_max;
  logic [48:0] wr_q[$];
  int          n_fail;
  int          samples_checked;
  int          cycles;

  // ---------------------------------------------------------------
  // parameter attribute table, decoded from the address bits
  // ---------------------------------------------------------------
  assign pa_ctrl     = pw_addr[14];
  assign pa_signed   = ~pw_addr[0];
  assign pa_long     = pw_addr[1];
  assign pa_writable = (pw_addr[3:0] != 4'hf);
  assign pa_min      = pa_signed ? 32'hffff_fc18 : 32'h0000_0000;
  assign pa_max      = pa_signed ? 32'h0000_03e8 : 32'h0001_0000;

  pwc_param_write u_pwc_param_write (
    .MCLK                        (mclk),
    .RSTN                        (rstn),
    .SLAVE_ADDR                  (8'h05),
    .RX_VALID                    (rx_valid),
    .RX_DATA                     (rx_data),
    .RX_END                      (rx_end),
    .TX_DATA                     (tx_data),
    .TX_VALID                    (tx_valid),
    .TX_LAST                     (tx_last),
    .TX_READY                    (tx_ready),
    .PW_ADDR                     (pw_addr),
    .PW_DATA                     (pw_data),
    .PW_WE                       (pw_we),
    .PW_RETAIN                   (pw_retain),
    .PA_SIGNED                   (pa_signed),
    .PA_LONG                     (pa_long),
    .PA_CTRL                     (pa_ctrl),
    .PA_WRITABLE                 (pa_writable),
    .PA_MIN                      (pa_min),
    .PA_MAX                      (pa_max),
    .POWER_LOSS_RETENTION_SELECT (retain_sel),
    .BUSY                        (busy)
  );

  pwc_host_model u_pwc_host_model (
    .MCLK     (mclk),
    .RX_VALID (rx_valid),
    .RX_DATA  (rx_data),
    .RX_END   (rx_end),
    .TX_DATA  (tx_data),
    .TX_VALID (tx_valid),
    .TX_LAST  (tx_last),
    .TX_READY (tx_ready)
  );

  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    retain_sel = 1'b1;
  end

  always #20 mclk = ~mclk;

  always @(posedge mclk)
  begin
    if (pw_we === 1'b1)
      wr_q.push_back({pw_retain, pw_addr, pw_data});
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // shared checking
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [48:0] got, input logic [48:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // send one frame, then judge the answer bytes and the writes it caused
  task automatic exchange(input logic [7:0] rq[$], input logic good,
                          input logic [7:0] ex[$], input logic [48:0] wx[$]);
    logic [8:0] got[$];
    logic [7:0] b[$];
    int         n;
    u_pwc_host_model.ans_q.delete();
    wr_q.delete();
    u_pwc_host_model.send(rq, good);
    repeat (3) @(posedge mclk);
    n = 0;
    while (busy !== 1'b0 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    chk(49'(busy), 49'h0);
    repeat (4) @(posedge mclk);
    got = u_pwc_host_model.ans_q;
    chk(49'(got.size()), 49'(ex.size() > 0 ? ex.size() + 2 : 0));
    foreach (ex[i])
      chk(49'(got[i][7:0]), 49'(ex[i]));
    foreach (got[i])
      b.push_back(got[i][7:0]);
    if (got.size() > 0)
    begin
      chk(49'(u_pwc_host_model.crc16(b)), 49'h0);
      chk(49'(got[got.size() - 1][8]), 49'h1);
    end
    chk(49'(wr_q.size()), 49'(wx.size()));
    foreach (wx[i])
      chk(wr_q[i], wx[i]);
  endtask : exchange

  // ---------------------------------------------------------------
  // scenarios; 16-bit values stay inside the 16-bit range
  // ---------------------------------------------------------------
  task automatic t_single_ok;
    logic [7:0]  rq[$];
    logic [48:0] wx[$];
    rq = '{8'h05, 8'h06, 8'h02, 8'h02, 8'hfe, 8'h0c};
    wx = '{{1'b1, 16'h0202, 32'hffff_fe0c}};
    exchange(rq, 1'b1, rq, wx);
    rq = '{8'h05, 8'h41, 8'h02, 8'h03, 8'hfe, 8'h0c};
    wx = '{{1'b0, 16'h0203, 32'h0000_fe0c}};
    exchange(rq, 1'b1, rq, wx);
    #1 retain_sel = 1'b0;
    rq = '{8'h05, 8'h06, 8'h02, 8'h00, 8'h00, 8'h05};
    wx = '{{1'b0, 16'h0200, 32'h0000_0005}};
    exchange(rq, 1'b1, rq, wx);
    #1 retain_sel = 1'b1;
  endtask : t_single_ok

  task automatic t_single_mode_bit;
    logic [7:0]  rq[$];
    logic [7:0]  ex[$];
    logic [48:0] wx[$];
    logic [7:0]  cmds[2];
    cmds = '{pwc_pkg::CMD_WR1, pwc_pkg::CMD_WR1_NR};
    foreach (cmds[i])
    begin
      rq = '{8'h05, cmds[i], 8'h82, 8'h02, 8'h00, 8'h01};
      ex = '{8'h05, cmds[i] | pwc_pkg::EXC_FLAG, pwc_pkg::EXC_ADDR};
      exchange(rq, 1'b1, ex, wx);
    end
  endtask : t_single_mode_bit

  task automatic t_single_reject;
    logic [7:0]  rq[$];
    logic [7:0]  ex[$];
    logic [48:0] wx[$];
    logic [7:0]  no_ans[$];
    ex = '{8'h05, 8'h86, pwc_pkg::EXC_DATA};
    rq = '{8'h05, 8'h06, 8'h02, 8'h02, 8'h11, 8'h94};
    exchange(rq, 1'b1, ex, wx);
    rq = '{8'h05, 8'h06, 8'h02, 8'h0f, 8'h00, 8'h01};
    exchange(rq, 1'b1, ex, wx);
    rq = '{8'h05, 8'h06, 8'h02, 8'h02, 8'h00, 8'h01};
    exchange(rq, 1'b0, no_ans, wx);
    // frame for another node: no answer, no write
    rq = '{8'h07, 8'h06, 8'h02, 8'h02, 8'h00, 8'h01};
    exchange(rq, 1'b1, no_ans, wx);
    rq = '{8'h05, 8'h03, 8'h02, 8'h02, 8'h00, 8'h01};
    ex = '{8'h05, 8'h83, pwc_pkg::EXC_FUNC};
    exchange(rq, 1'b1, ex, wx);
  endtask : t_single_reject

  task automatic t_multi_32;
    logic [7:0]  rq[$];
    logic [7:0]  ex[$];
    logic [48:0] wx[$];
    logic [48:0] no_wr[$];
    // slow sink: the answer must wait for every acceptance
    u_pwc_host_model.stall = 1'b1;
    rq = '{8'h05, 8'h10, 8'h82, 8'h00, 8'h00, 8'h04, 8'h08,
           8'hff, 8'hff, 8'hfc, 8'h18, 8'h00, 8'h01, 8'h00, 8'h00};
    ex = rq[0:5];
    wx = '{{1'b1, 16'h0200, 32'hffff_fc18}, {1'b1, 16'h0201, 32'h0001_0000}};
    exchange(rq, 1'b1, ex, wx);
    rq = '{8'h05, 8'h10, 8'h82, 8'h00, 8'h00, 8'h03, 8'h06,
           8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02};
    ex = '{8'h05, 8'h90, pwc_pkg::EXC_DATA};
    exchange(rq, 1'b1, ex, no_wr);
    u_pwc_host_model.stall = 1'b0;
  endtask : t_multi_32

  task automatic t_multi_classes;
    logic [7:0]  rq[$];
    logic [7:0]  ex[$];
    logic [48:0] wx[$];
    ex = '{8'h05, 8'hc3, pwc_pkg::EXC_DATA};
    rq = '{8'h05, 8'h43, 8'h02, 8'h00, 8'h00, 8'h03, 8'h06,
           8'h00, 8'h01, 8'h00, 8'h02, 8'h11, 8'h94};
    exchange(rq, 1'b1, ex, wx);
    rq = '{8'h05, 8'h43, 8'h42, 8'h00, 8'h00, 8'h03, 8'h06,
           8'h00, 8'h07, 8'h00, 8'h08, 8'h70, 8'h00};
    wx = '{{1'b0, 16'h4200, 32'h0000_0007}, {1'b0, 16'h4201, 32'h0000_0008}};
    exchange(rq, 1'b1, ex, wx);
  endtask : t_multi_classes

  initial
  begin
    repeat (16) @(posedge mclk);
    #1;
    rstn = 1'b1;
    repeat (5) @(posedge mclk);
    t_single_ok();
    t_single_mode_bit();
    t_single_reject();
    t_multi_32();
    t_multi_classes();
    report_and_stop();
  end
endmodule : test_param_write_command_handler
`default_nettype wire
